// file: verilog/clocked_serial_unit.sv
// single-transfer clocked serial unit with register port
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module clocked_serial_unit
  import serial_unit_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              RSTN,
  input  wire logic [ADDR_W-1:0] ADDR,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [DATA_W-1:0] RDATA,
  input  wire logic              SERIAL_CLOCK_PIN_IN,
  output logic                   SERIAL_CLOCK_PIN_OUT,
  output logic                   SERIAL_CLOCK_PIN_OE_N,
  output logic                   SERIAL_OUTPUT_PIN,
  input  wire logic              SERIAL_INPUT_PIN,
  output logic                   RECEIVE_COMPLETE_IRQ,
  output logic                   TRANSMIT_READY_IRQ
);

  function automatic logic [4:0] word_len(input logic [3:0] field);
    word_len = field[3] ? WORD_LEN_MAX : WORD_LEN_BASE + {2'b00, field[2:0]};
  endfunction

  // buffer bit carried by shift step idx, data always LSB aligned
  function automatic logic [3:0] bit_pos(input logic [4:0] idx, input logic [4:0] len,
                                         input logic lsb_first);
    logic [4:0] p;
    p = lsb_first ? idx : len - 5'd1 - idx;
    bit_pos = p[3:0];
  endfunction

  main_ctrl_t         main_control_reg;
  timing_ctrl_t       timing_control_reg;
  logic [3:0]         word_length_field;
  xfer_state_t        state;
  logic               overrun_flag;
  logic               rx_unread;
  logic [DATA_W-1:0]  transmit_buffer;
  logic [DATA_W-1:0]  receive_buffer;
  logic [DATA_W-1:0]  rx_shift;
  logic [4:0]         idx;
  logic [DIV_W-1:0]   div_cnt;
  logic               sck_lvl;
  logic               sync1;
  logic               sync2;
  logic               sync3;
  logic               sout;
  logic               irq;
  logic [DATA_W-1:0]  rdata;

  main_ctrl_t         next_main_control_reg;
  timing_ctrl_t       next_timing_control_reg;
  logic [3:0]         next_word_length_field;
  xfer_state_t        next_state;
  logic               next_overrun_flag;
  logic               next_rx_unread;
  logic [DATA_W-1:0]  next_transmit_buffer;
  logic [DATA_W-1:0]  next_receive_buffer;
  logic [DATA_W-1:0]  next_rx_shift;
  logic [4:0]         next_idx;
  logic [DIV_W-1:0]   next_div_cnt;
  logic               next_sck_lvl;
  logic               next_sout;
  logic               next_irq;
  logic [DATA_W-1:0]  next_rdata;

  logic               slave;
  logic               idle_lvl;
  logic               running;
  logic               tick;
  logic               lead;
  logic               trail;
  logic               sample;
  logic               shift;
  logic               start_tx;
  logic               start_rx;
  logic               rx_read;
  logic               done;
  logic [4:0]         len;
  logic [DIV_W-1:0]   half;

  always_comb begin
    len      = word_len(word_length_field);
    slave    = timing_control_reg.clock_source_field == CLK_SRC_EXT;
    idle_lvl = ~timing_control_reg.clock_polarity_select;
    running  = state == XFER_RUN;
    // source 000 toggles every cycle, period of two system clocks
    half     = DIV_W'(7'h01 << timing_control_reg.clock_source_field);
    tick     = running && !slave && (div_cnt == half - 7'h01);
    if (slave) begin
      // only the synchronised copies are looked at; idle clocks are ignored
      lead  = running && (sync2 != idle_lvl) && (sync3 == idle_lvl);
      trail = running && (sync2 == idle_lvl) && (sync3 != idle_lvl);
    end else begin
      lead  = tick && (sck_lvl == idle_lvl);
      trail = tick && (sck_lvl != idle_lvl);
    end
    sample = timing_control_reg.data_phase_select ? lead : trail;
    shift  = timing_control_reg.data_phase_select ? trail : lead;
    rx_read  = RD && (ADDR == RX_BUF_ADDR);
    start_tx = WR && (ADDR == TX_BUF_ADDR) && !running
               && main_control_reg.unit_power_bit && main_control_reg.transmit_enable_bit;
    start_rx = rx_read && !running && main_control_reg.unit_power_bit
               && main_control_reg.receive_enable_bit && !main_control_reg.transmit_enable_bit
               && main_control_reg.continue_receive_bit;

    next_main_control_reg   = main_control_reg;
    next_timing_control_reg = timing_control_reg;
    next_word_length_field  = word_length_field;
    next_state              = state;
    next_overrun_flag       = overrun_flag;
    next_rx_unread          = rx_unread;
    next_transmit_buffer    = transmit_buffer;
    next_receive_buffer     = receive_buffer;
    next_rx_shift           = rx_shift;
    next_idx                = idx;
    next_div_cnt            = div_cnt;
    next_sck_lvl            = idle_lvl;
    next_sout               = sout;
    next_irq                = 1'b0;
    next_rdata              = '0;
    done                    = 1'b0;

    // register writes and reads
    if (WR) begin
      case (ADDR)
        MAIN_CTRL_ADDR:   next_main_control_reg = main_ctrl_t'(WDATA[7:0]);
        TIMING_CTRL_ADDR: next_timing_control_reg = timing_ctrl_t'(WDATA[7:0]);
        LENGTH_CTRL_ADDR: next_word_length_field = WDATA[3:0];
        STATUS_ADDR:      next_overrun_flag = overrun_flag & WDATA[OVERRUN_BIT];
        default:          next_overrun_flag = next_overrun_flag;
      endcase
    end
    if (RD) begin
      case (ADDR)
        MAIN_CTRL_ADDR:   next_rdata = {8'h00, main_control_reg};
        TIMING_CTRL_ADDR: next_rdata = {8'h00, timing_control_reg};
        LENGTH_CTRL_ADDR: next_rdata = {12'h000, word_length_field};
        STATUS_ADDR: begin
          next_rdata[BUSY_BIT]    = running;
          next_rdata[OVERRUN_BIT] = overrun_flag;
        end
        TX_BUF_ADDR:      next_rdata = transmit_buffer;
        RX_BUF_ADDR:      next_rdata = receive_buffer;
        default:          next_rdata = '0;
      endcase
    end
    if (rx_read) begin
      next_rx_unread = 1'b0;
    end

    case (state)
      XFER_IDLE: begin
        next_div_cnt = '0;
        if (start_tx || start_rx) begin
          next_state    = XFER_RUN;
          next_idx      = '0;
          next_rx_shift = '0;
          if (start_tx) begin
            next_transmit_buffer = WDATA;
            if (timing_control_reg.data_phase_select) begin
              next_sout = WDATA[bit_pos(5'd0, len, main_control_reg.bit_order_select)];
            end
          end
        end
      end
      XFER_RUN: begin
        next_sck_lvl = sck_lvl;
        if (!slave) begin
          next_div_cnt = tick ? '0 : div_cnt + 7'h01;
          if (tick) begin
            next_sck_lvl = ~sck_lvl;
          end
        end
        if (shift && (idx < len) && main_control_reg.transmit_enable_bit) begin
          next_sout = transmit_buffer[bit_pos(idx, len, main_control_reg.bit_order_select)];
        end
        if (sample) begin
          if (main_control_reg.receive_enable_bit) begin
            next_rx_shift[bit_pos(idx, len, main_control_reg.bit_order_select)] =
              SERIAL_INPUT_PIN;
          end
          next_idx = idx + 5'd1;
        end
        if (trail && (next_idx == len)) begin
          done         = 1'b1;
          next_state   = XFER_IDLE;
          next_sck_lvl = idle_lvl;
          next_irq     = 1'b1;
          if (main_control_reg.receive_enable_bit) begin
            next_receive_buffer = next_rx_shift;
            next_rx_unread      = 1'b1;
            if (rx_unread && !rx_read) begin
              next_overrun_flag = 1'b1;
            end
          end
        end
      end
      default: next_state = XFER_IDLE;
    endcase

    // power off drops the transfer and clears the status
    if (!next_main_control_reg.unit_power_bit) begin
      next_state        = XFER_IDLE;
      next_overrun_flag = 1'b0;
      next_rx_unread    = 1'b0;
      next_sck_lvl      = ~next_timing_control_reg.clock_polarity_select;
      if (!done) begin
        next_irq = 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      main_control_reg   <= main_ctrl_t'(MAIN_CTRL_RST);
      timing_control_reg <= timing_ctrl_t'(TIMING_CTRL_RST);
      word_length_field  <= LENGTH_CTRL_RST;
      state              <= XFER_IDLE;
      overrun_flag       <= 1'b0;
      rx_unread          <= 1'b0;
      transmit_buffer    <= BUF_RST;
      receive_buffer     <= BUF_RST;
      rx_shift           <= BUF_RST;
      idx                <= 5'h00;
      div_cnt            <= '0;
      sck_lvl            <= 1'b1;
      sync1              <= 1'b1;
      sync2              <= 1'b1;
      sync3              <= 1'b1;
      sout               <= 1'b1;
      irq                <= 1'b0;
      rdata              <= BUF_RST;
    end else begin
      main_control_reg   <= next_main_control_reg;
      timing_control_reg <= next_timing_control_reg;
      word_length_field  <= next_word_length_field;
      state              <= next_state;
      overrun_flag       <= next_overrun_flag;
      rx_unread          <= next_rx_unread;
      transmit_buffer    <= next_transmit_buffer;
      receive_buffer     <= next_receive_buffer;
      rx_shift           <= next_rx_shift;
      idx                <= next_idx;
      div_cnt            <= next_div_cnt;
      sck_lvl            <= next_sck_lvl;
      sync1              <= SERIAL_CLOCK_PIN_IN;
      sync2              <= sync1;
      sync3              <= sync2;
      sout               <= next_sout;
      irq                <= next_irq;
      rdata              <= next_rdata;
    end
  end

  assign RDATA                 = rdata;
  assign SERIAL_CLOCK_PIN_OUT  = sck_lvl;
  assign SERIAL_CLOCK_PIN_OE_N = slave || !main_control_reg.unit_power_bit;
  assign SERIAL_OUTPUT_PIN     = sout;
  assign RECEIVE_COMPLETE_IRQ  = irq;
  assign TRANSMIT_READY_IRQ    = 1'b0;

endmodule

// file: verilog/serial_unit_pkg.sv
// register map, field layouts and types of the clocked serial unit
package serial_unit_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  localparam logic [2:0] MAIN_CTRL_ADDR   = 3'h0;
  localparam logic [2:0] TIMING_CTRL_ADDR = 3'h1;
  localparam logic [2:0] LENGTH_CTRL_ADDR = 3'h2;
  localparam logic [2:0] STATUS_ADDR      = 3'h3;
  localparam logic [2:0] TX_BUF_ADDR      = 3'h4;
  localparam logic [2:0] RX_BUF_ADDR      = 3'h5;

  localparam logic [7:0]  MAIN_CTRL_RST   = 8'h00;
  localparam logic [7:0]  TIMING_CTRL_RST = 8'h00;
  localparam logic [3:0]  LENGTH_CTRL_RST = 4'h0;
  localparam logic [15:0] BUF_RST         = 16'h0000;

  localparam logic [2:0] CLK_SRC_EXT   = 3'h7;
  localparam logic [4:0] WORD_LEN_BASE = 5'h08;
  localparam logic [4:0] WORD_LEN_MAX  = 5'h10;
  localparam int         BUSY_BIT      = 7;
  localparam int         OVERRUN_BIT   = 0;
  localparam int         DIV_W         = 7;

  typedef struct packed {
    logic       unit_power_bit;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
    logic       bit_order_select;
    logic [2:0] unused;
    logic       continue_receive_bit;
  } main_ctrl_t;

  typedef struct packed {
    logic [2:0] unused;
    logic       clock_polarity_select;
    logic       data_phase_select;
    logic [2:0] clock_source_field;
  } timing_ctrl_t;

  typedef enum logic {XFER_IDLE, XFER_RUN} xfer_state_t;

endpackage

// file: dv/serial_peer.sv
// external serial peer: swaps one byte with the unit, clocks it in slave mode
`timescale 1ns/1ps
module serial_peer (
  input  wire logic ref_clk,
  input  wire logic sck,
  input  wire logic sout,
  output logic      sin,
  output logic      sck_drive
);
  logic [7:0] send;
  logic [7:0] got;
  initial begin
    sin       = 1'b1;
    sck_drive = 1'b1;
    send      = 8'h00;
    got       = 8'h00;
  end
  // refill with inverted bits so a second word differs from the first
  always @(negedge sck) begin
    sin  <= send[7];
    send <= {send[6:0], ~send[7]};
  end
  always @(posedge sck) begin
    got <= {got[6:0], sout};
  end
  // only called once the unit has been started
  task automatic clock_word(input int half);
    repeat (8) begin
      repeat (half) @(posedge ref_clk);
      sck_drive <= 1'b0;
      repeat (half) @(posedge ref_clk);
      sck_drive <= 1'b1;
    end
  endtask
endmodule

// file: dv/serial_unit_checker.sv
// port-level assertions for the clocked serial unit
`timescale 1ns/1ps
module serial_unit_checker
  import serial_unit_pkg::*;
(
  input wire logic              REF_CLK,
  input wire logic              RSTN,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic              WR,
  input wire logic              RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic              SERIAL_CLOCK_PIN_IN,
  input wire logic              SERIAL_CLOCK_PIN_OUT,
  input wire logic              SERIAL_CLOCK_PIN_OE_N,
  input wire logic              SERIAL_OUTPUT_PIN,
  input wire logic              SERIAL_INPUT_PIN,
  input wire logic              RECEIVE_COMPLETE_IRQ,
  input wire logic              TRANSMIT_READY_IRQ
);
  logic [7:0] main_q;
  logic [7:0] tim_q;
  logic [3:0] len_q;
  logic       act;
  logic [4:0] falls;
  logic [4:0] exp_len;
  logic       start;
  logic       mwr;
  logic       mst;
  assign mwr     = WR && ADDR == MAIN_CTRL_ADDR;
  assign mst     = main_q[7] && tim_q[2:0] != CLK_SRC_EXT;
  assign exp_len = len_q[3] ? WORD_LEN_MAX : WORD_LEN_BASE + {2'b00, len_q[2:0]};
  // the completion cycle is already idle, so a new start may land there
  assign start   = (!act || RECEIVE_COMPLETE_IRQ) && main_q[7]
                 && ((WR && ADDR == TX_BUF_ADDR && main_q[6])
                 || (RD && ADDR == RX_BUF_ADDR && main_q[5] && !main_q[6] && main_q[0]));
  // mirror of the control registers and of the busy state
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      main_q <= 8'h00;
      tim_q  <= 8'h00;
      len_q  <= 4'h0;
      act    <= 1'b0;
      falls  <= 5'h00;
    end else begin
      if (mwr) main_q <= WDATA[7:0];
      if (WR && ADDR == TIMING_CTRL_ADDR) tim_q <= WDATA[7:0];
      if (WR && ADDR == LENGTH_CTRL_ADDR) len_q <= WDATA[3:0];
      if (start) act <= 1'b1;
      else if (RECEIVE_COMPLETE_IRQ || (mwr && !WDATA[7])) act <= 1'b0;
      if (start) falls <= 5'h00;
      else if ($fell(SERIAL_CLOCK_PIN_OUT) && !SERIAL_CLOCK_PIN_OE_N) falls <= falls + 5'h01;
    end
  end
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  sequence master_go;
    start && !SERIAL_CLOCK_PIN_OE_N && tim_q[2:0] == 3'h0;
  endsequence
  sequence first_fall;
    ##[1:3] $fell(SERIAL_CLOCK_PIN_OUT);
  endsequence
  a_no_ready_irq: assert property (!TRANSMIT_READY_IRQ)
    else $error("ready interrupt raised");
  a_irq_single: assert property (RECEIVE_COMPLETE_IRQ |=> !RECEIVE_COMPLETE_IRQ)
    else $error("completion pulse too long");
  a_clock_owner: assert property (SERIAL_CLOCK_PIN_OE_N == !mst)
    else $error("clock pin ownership wrong");
  a_master_start: assert property (master_go |-> first_fall)
    else $error("master clock did not start");
  a_master_done: assert property (master_go ##0 len_q == 4'h0 |-> ##[14:20] RECEIVE_COMPLETE_IRQ)
    else $error("master word did not end");
  a_word_length: assert property (RECEIVE_COMPLETE_IRQ && mst |-> falls == exp_len)
    else $error("clock count wrong");
  a_irq_busy: assert property (RECEIVE_COMPLETE_IRQ |-> act)
    else $error("completion without transfer");
  a_clock_quiet: assert property (!act && !start |=> $stable(SERIAL_CLOCK_PIN_OUT))
    else $error("clock moved while idle");
  a_data_quiet: assert property (!act && !start |=> $stable(SERIAL_OUTPUT_PIN))
    else $error("data moved while idle");
endmodule
bind clocked_serial_unit serial_unit_checker u_chk (
  .REF_CLK(REF_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .SERIAL_CLOCK_PIN_IN(SERIAL_CLOCK_PIN_IN),
  .SERIAL_CLOCK_PIN_OUT(SERIAL_CLOCK_PIN_OUT), .SERIAL_CLOCK_PIN_OE_N(SERIAL_CLOCK_PIN_OE_N),
  .SERIAL_OUTPUT_PIN(SERIAL_OUTPUT_PIN), .SERIAL_INPUT_PIN(SERIAL_INPUT_PIN),
  .RECEIVE_COMPLETE_IRQ(RECEIVE_COMPLETE_IRQ), .TRANSMIT_READY_IRQ(TRANSMIT_READY_IRQ));

// file: dv/tb.sv
// self-checking bench for the clocked serial unit
`timescale 1ns/1ps
module tb
  import serial_unit_pkg::*;
;
  logic              ref_clk;
  logic              rstn;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              wr;
  logic              rd;
  logic [DATA_W-1:0] rdata;
  logic              sck_out;
  logic              oe_n;
  logic              sout;
  logic              sin;
  logic              irq;
  logic              peer_sck;
  logic              sck;
  int                fail_count = 0;
  int                checks_done = 0;
  assign sck = oe_n ? peer_sck : sck_out;
  clocked_serial_unit dut (.REF_CLK(ref_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .SERIAL_CLOCK_PIN_IN(sck),
    .SERIAL_CLOCK_PIN_OUT(sck_out), .SERIAL_CLOCK_PIN_OE_N(oe_n), .SERIAL_OUTPUT_PIN(sout),
    .SERIAL_INPUT_PIN(sin), .RECEIVE_COMPLETE_IRQ(irq), .TRANSMIT_READY_IRQ());
  serial_peer peer (.ref_clk(ref_clk), .sck(sck), .sout(sout), .sin(sin), .sck_drive(peer_sck));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask
  // one strobe cycle; ends 1 ns after the edge so strobes never change twice at once
  task automatic bus(input logic w, input logic r, input logic [2:0] a, input logic [15:0] d);
    wr    <= w;
    rd    <= r;
    addr  <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr    <= 1'b0;
    rd    <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [15:0] e, input string n);
    bus(1'b0, 1'b1, a, 16'h0000);
    chk(n, rdata, e);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("completion irq", {15'h0000, irq}, 16'h0001);
  endtask
  task automatic stop_test;
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #50us;
    fail_count++;
    stop_test();
  end
  initial begin
    rstn  = 1'b0;
    wr    = 1'b0;
    rd    = 1'b0;
    addr  = 3'h0;
    wdata = 16'h0000;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 8; i++) if (i != 4 && i != 5) rd_chk(3'(i), 16'h0000, "reset");
    bus(1'b1, 1'b0, TIMING_CTRL_ADDR, 16'h0000);
    bus(1'b1, 1'b0, LENGTH_CTRL_ADDR, 16'h0000);
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h00e1);
    peer.send = 8'h5a;
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h00c3);
    rd_chk(STATUS_ADDR, 16'h0080, "busy");
    wait_irq();
    rd_chk(STATUS_ADDR, 16'h0000, "idle");
    rd_chk(RX_BUF_ADDR, 16'h005a, "rx word");
    chk("tx word", {8'h00, peer.got}, 16'h00c3);
    peer.send = 8'ha5;
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h0001);
    wait_irq();
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h0002);
    wait_irq();
    rd_chk(STATUS_ADDR, 16'h0001, "overrun");
    bus(1'b1, 1'b0, STATUS_ADDR, 16'h0000);
    rd_chk(STATUS_ADDR, 16'h0000, "overrun clear");
    rd_chk(RX_BUF_ADDR, 16'h005a, "second word");
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h00c1);
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h0081);
    wait_irq();
    chk("tx only", {8'h00, peer.got}, 16'h0081);
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h00a1);
    peer.send = 8'h96;
    bus(1'b0, 1'b1, RX_BUF_ADDR, 16'h0000);
    rd_chk(STATUS_ADDR, 16'h0080, "armed");
    wait_irq();
    rd_chk(RX_BUF_ADDR, 16'h0096, "rx only");
    rd_chk(STATUS_ADDR, 16'h0080, "rearmed");
    wait_irq();
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h00a0);
    rd_chk(RX_BUF_ADDR, 16'h0069, "last word");
    rd_chk(STATUS_ADDR, 16'h0000, "no rearm");
    // 11-bit word at half period of two cycles, then an LSB-first byte
    bus(1'b1, 1'b0, TIMING_CTRL_ADDR, 16'h0001);
    bus(1'b1, 1'b0, LENGTH_CTRL_ADDR, 16'h0003);
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h00e1);
    peer.send = 8'h12;
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h05a5);
    wait_irq();
    rd_chk(RX_BUF_ADDR, 16'h0097, "short rx");
    chk("short tx", {8'h00, peer.got}, 16'h00a5);
    bus(1'b1, 1'b0, LENGTH_CTRL_ADDR, 16'h0000);
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h00f1);
    peer.send = 8'h80;
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h0001);
    wait_irq();
    rd_chk(RX_BUF_ADDR, 16'h0001, "lsb rx");
    chk("lsb tx", {8'h00, peer.got}, 16'h0080);
    bus(1'b1, 1'b0, TIMING_CTRL_ADDR, 16'h0007);
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h00e1);
    peer.send = 8'h3c;
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h00e7);
    repeat (20) @(posedge ref_clk);
    rd_chk(STATUS_ADDR, 16'h0080, "slave waits");
    peer.clock_word(5);
    wait_irq();
    chk("slave tx", {8'h00, peer.got}, 16'h00e7);
    rd_chk(RX_BUF_ADDR, 16'h003c, "slave rx");
    bus(1'b1, 1'b0, TX_BUF_ADDR, 16'h0011);
    bus(1'b1, 1'b0, MAIN_CTRL_ADDR, 16'h0000);
    rd_chk(STATUS_ADDR, 16'h0000, "power off");
    stop_test();
  end
endmodule
